//--- bench/ftsm_fan_model.sv
/*
  Fan-side model: turns the duty of drive output 3 into a pulse level.
  Assumes the duty comes from the block under test, on the same clock.
*/
`timescale 1ns/1ns

module ftsm_fan_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Duty in, pulse level out
  input  wire logic [7:0] duty_in,
  output logic            level_out
);
  logic [7:0] cnt_ff;

  // Free-running period counter; level is high while below the duty
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  assign level_out = (cnt_ff < duty_in);
endmodule // ftsm_fan_model

//--- bench/tb.sv
/*
  Self-checking bench of the fan sync and floor block.
  Assumes the register port answers reads one cycle after the strobe.
*/
`timescale 1ns/1ns
`include "ftsm_regs.svh"

module tb;
  logic            clk = 0, rst_n = 0, wr = 0, rd = 0, lvl, lvl_q = 0, locked;
  logic [7:0]      addr = 8'h00, wdata = 8'h00, rdata, v, e;
  logic [2:0]      auto_m = 3'h0, below = 3'h0, gate;
  logic [2:0][7:0] calc = '0, mind = '0, duty;
  integer          n_fail = 0, n_tests = 0, seed = 32'h401c, cyc = 0, sf = 0, ac = 0, i, j, k;

  ftsm_ctrl DUT (.MCLK_IN(clk), .RESET_N_IN(rst_n), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .AUTO_MODE_IN(auto_m), .BELOW_HYST_IN(below), .CALC_DUTY_IN(calc),
    .MIN_DUTY_IN(mind), .FAN_DRIVE_OUTPUT_3_LEVEL_IN(lvl),
    .FAN_DRIVE_OUTPUT_DUTY_OUT(duty), .SPEED_SENSE_GATE_OUT(gate), .LOCKED_OUT(locked));

  ftsm_fan_model fan (.clk_in(clk), .rst_n_in(rst_n), .duty_in(duty[2]), .level_out(lvl));

  initial forever #2 clk = ~clk;

  // Level held from the falling edge, so it equals what the rising edge sees
  always @(negedge clk) lvl_q <= lvl;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude;
    end
  end

  task conclude;
    $display("fails %0d tests %0d", n_fail, n_tests);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask

  task rd8(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 d = rdata;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd8(`FTSM_ADDR_ACOU2, v); chk("acou2 reset", v, `FTSM_RST_ACOU2);
    rd8(8'h55, v);
    chk("unmapped", v, `FTSM_RDATA_IDLE);
    @(posedge clk);
    #1 chk("rdata idle", rdata, `FTSM_RDATA_IDLE);
    rd8(`FTSM_ADDR_CONFIG, v);
    chk("config open", v, 8'h00);
    chk("unlocked", {7'h00, locked}, 8'h00);
    ac = $random(seed) & 255;
    wr8(`FTSM_ADDR_ACOU2, ac[7:0]);
    rd8(`FTSM_ADDR_ACOU2, v); chk("acou2", v, ac[7:0]);
    // Every sync and floor combination against random loop inputs
    for (k = 0; k < 16; k++) begin
      sf = (k << 4) | ($random(seed) & 15);
      wr8(`FTSM_ADDR_SYNC_FLOOR, sf[7:0]);
      rd8(`FTSM_ADDR_SYNC_FLOOR, v); chk("sync_floor", v, sf[7:0]);
      for (i = 0; i < 20; i++) begin
        @(posedge clk);
        auto_m <= 3'($random(seed));
        below  <= 3'($random(seed));
        calc   <= 24'($random(seed));
        mind   <= 24'($random(seed));
        @(posedge clk);
        #1;
        for (j = 0; j < 3; j++) begin
          e = (auto_m[j] & below[j]) ? (sf[5+j] ? mind[j] : `FTSM_DUTY_OFF) : calc[j];
          chk("duty", duty[j], e);
        end
        chk("gate", {5'h00, gate}, {5'h00, lvl_q, lvl_q, sf[4] ? lvl_q : 1'b1});
        rd8(`FTSM_ADDR_STATUS, v);
        chk("status", v, {2'b00, auto_m & below & sf[7:5], auto_m & below});
      end
    end
    // Lock freezes both settings registers
    wr8(`FTSM_ADDR_CONFIG, 8'h01 << `FTSM_BIT_LOCK);
    #1 chk("locked", {7'h00, locked}, 8'h01);
    wr8(`FTSM_ADDR_SYNC_FLOOR, ~sf[7:0]);
    wr8(`FTSM_ADDR_ACOU2, ~ac[7:0]);
    rd8(`FTSM_ADDR_SYNC_FLOOR, v); chk("locked sync_floor", v, sf[7:0]);
    rd8(`FTSM_ADDR_ACOU2, v); chk("locked acou2", v, ac[7:0]);
    rd8(`FTSM_ADDR_CONFIG, v);
    chk("config locked", v, 8'h01 << `FTSM_BIT_LOCK);
    wr8(`FTSM_ADDR_CONFIG, 8'h00);
    #1 chk("lock sticks", {7'h00, locked}, 8'h01);
    // Reset in mid-run must reopen the lock and restore the defaults
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("lock after reset", {7'h00, locked}, 8'h00);
    rd8(`FTSM_ADDR_ACOU2, v);
    chk("acou2 reset again", v, `FTSM_RST_ACOU2);
    rd8(`FTSM_ADDR_SYNC_FLOOR, v);
    chk("sync_floor reset", v, `FTSM_RST_SYNC_FLOOR);
    wr8(`FTSM_ADDR_ACOU2, ~ac[7:0]);
    rd8(`FTSM_ADDR_ACOU2, v);
    chk("acou2 reopened", v, ~ac[7:0]);
    conclude;
  end
endmodule // tb

//--- rtl/ftsm_ctrl.sv
/*
  Sync and below-threshold floor settings for three fan drive outputs,
  with a global lock. Registers sit on a plain strobe port; read data
  stands in the cycle after the read strobe only.
  Assumes all inputs are synchronous to MCLK_IN and that the automatic
  loop supplies its computed duty, the minimum duty and the
  below-threshold indication per drive output.
*/
// Design decision made here: the address-and-strobe port.
//
// What this block does
// - Sync bit one: sense 2-4 follow drive 3
// - Sync bit zero: only sense 3-4 follow
// - Drive 1 below threshold: off or minimum
// - Drive 2 below threshold: off or minimum
// - Drive 3 below threshold: off or minimum
// - Lock set: settings registers ignore writes
// - Register 0x63 resets to 0x00
//
`timescale 1ns/1ns
`include "ftsm_regs.svh"

module ftsm_ctrl (
  // Clock and reset
  input  wire logic                   MCLK_IN,
  input  wire logic                   RESET_N_IN,
  // Register port
  input  wire logic [7:0]             REG_ADDR_IN,
  input  wire logic [7:0]             REG_WDATA_IN,
  input  wire logic                   REG_WR_IN,
  input  wire logic                   REG_RD_IN,
  output logic      [7:0]             REG_RDATA_OUT,
  // Automatic loop, per drive output
  input  wire logic [2:0]             AUTO_MODE_IN,
  input  wire logic [2:0]             BELOW_HYST_IN,
  input  wire logic [2:0][7:0]        CALC_DUTY_IN,
  input  wire logic [2:0][7:0]        MIN_DUTY_IN,
  // Drive output 3 level for speed sense gating
  input  wire logic                   FAN_DRIVE_OUTPUT_3_LEVEL_IN,
  // Outputs
  output logic      [2:0][7:0]        FAN_DRIVE_OUTPUT_DUTY_OUT,
  output logic      [2:0]             SPEED_SENSE_GATE_OUT,
  output logic                        LOCKED_OUT
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ftsm_pkg::ftsm_state_t state_ff;
  ftsm_pkg::ftsm_state_t nxt_state;

  logic                  wr_unlocked;
  logic                  sync_bit;
  logic [2:0]            floor_bits;

  assign sync_bit   = state_ff.sync_floor[`FTSM_BIT_SYNC];
  assign floor_bits = state_ff.sync_floor[`FTSM_BIT_FLOOR3:`FTSM_BIT_FLOOR1];
  assign wr_unlocked = REG_WR_IN && !state_ff.lock;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;

    // Lock is set-once: only reset clears it, so a runaway write
    // cannot reopen the settings.
    if (REG_WR_IN && REG_ADDR_IN == `FTSM_ADDR_CONFIG &&
        REG_WDATA_IN[`FTSM_BIT_LOCK]) begin
      nxt_state.lock = 1'b1;
    end

    if (wr_unlocked && REG_ADDR_IN == `FTSM_ADDR_SYNC_FLOOR) begin
      nxt_state.sync_floor = REG_WDATA_IN;
    end
    if (wr_unlocked && REG_ADDR_IN == `FTSM_ADDR_ACOU2) begin
      nxt_state.acou2 = REG_WDATA_IN;
    end

    // Read data lives for one cycle only; unmapped reads return zero
    nxt_state.rdata = `FTSM_RDATA_IDLE;
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        `FTSM_ADDR_CONFIG: begin
          nxt_state.rdata = `FTSM_RDATA_IDLE;
          nxt_state.rdata[`FTSM_BIT_LOCK] = state_ff.lock;
        end
        `FTSM_ADDR_STATUS: begin
          nxt_state.rdata = {2'b00, state_ff.below_active & floor_bits,
                             state_ff.below_active};
        end
        `FTSM_ADDR_SYNC_FLOOR: begin
          nxt_state.rdata = state_ff.sync_floor;
        end
        `FTSM_ADDR_ACOU2: begin
          nxt_state.rdata = state_ff.acou2;
        end
        default: begin
          nxt_state.rdata = `FTSM_RDATA_IDLE;
        end
      endcase
    end

    for (int ch = 0; ch < `FTSM_CHANNELS; ch++) begin
      nxt_state.below_active[ch] = AUTO_MODE_IN[ch] && BELOW_HYST_IN[ch];
      if (AUTO_MODE_IN[ch] && BELOW_HYST_IN[ch]) begin
        nxt_state.duty[ch] = floor_bits[ch] ? MIN_DUTY_IN[ch] : `FTSM_DUTY_OFF;
      end else begin
        nxt_state.duty[ch] = CALC_DUTY_IN[ch];
      end
    end

    // sense lockstep
    // Gate high means free running measurement; in lockstep the
    // sense input is only counted while drive output 3 is on.
    nxt_state.sense_gate[0] = sync_bit ? FAN_DRIVE_OUTPUT_3_LEVEL_IN : 1'b1;
    nxt_state.sense_gate[1] = FAN_DRIVE_OUTPUT_3_LEVEL_IN;
    nxt_state.sense_gate[2] = FAN_DRIVE_OUTPUT_3_LEVEL_IN;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_ff.acou2        <= `FTSM_RST_ACOU2;
      state_ff.sync_floor   <= `FTSM_RST_SYNC_FLOOR;
      state_ff.lock         <= 1'b0;
      state_ff.rdata        <= `FTSM_RDATA_IDLE;
      state_ff.duty         <= '0;
      state_ff.sense_gate   <= 3'h7;
      state_ff.below_active <= 3'h0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign REG_RDATA_OUT             = state_ff.rdata;
  assign FAN_DRIVE_OUTPUT_DUTY_OUT = state_ff.duty;
  assign SPEED_SENSE_GATE_OUT      = state_ff.sense_gate;
  assign LOCKED_OUT                = state_ff.lock;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge MCLK_IN);
  endclocking

  default disable iff (!RESET_N_IN);

  logic rst_seen_ff;

  // Marks the first edge after reset release
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rst_seen_ff <= 1'b0;
    end else begin
      rst_seen_ff <= 1'b1;
    end
  end

  // Guarding on the sampled reset keeps the edge that releases reset,
  // where the state is still held, out of the one-cycle checks.
  property p_sync_on;
    RESET_N_IN && sync_bit |=> SPEED_SENSE_GATE_OUT ==
                 {3{$past(FAN_DRIVE_OUTPUT_3_LEVEL_IN)}};
  endproperty
  a_sync_on: assert property (p_sync_on)
    else $error("sense 2-4 not locked to drive 3");

  property p_sync_off;
    RESET_N_IN && !sync_bit |=> SPEED_SENSE_GATE_OUT[0] &&
                  SPEED_SENSE_GATE_OUT[2:1] ==
                  {2{$past(FAN_DRIVE_OUTPUT_3_LEVEL_IN)}};
  endproperty
  a_sync_off: assert property (p_sync_off)
    else $error("sense 2 not free or sense 3-4 not locked");

  property p_floor1;
    AUTO_MODE_IN[0] && BELOW_HYST_IN[0] |=>
      FAN_DRIVE_OUTPUT_DUTY_OUT[0] ==
      ($past(floor_bits[0]) ? $past(MIN_DUTY_IN[0]) : 8'h00);
  endproperty
  a_floor1: assert property (p_floor1)
    else $error("drive 1 floor duty wrong");

  property p_floor2;
    AUTO_MODE_IN[1] && BELOW_HYST_IN[1] |=>
      FAN_DRIVE_OUTPUT_DUTY_OUT[1] ==
      ($past(floor_bits[1]) ? $past(MIN_DUTY_IN[1]) : 8'h00);
  endproperty
  a_floor2: assert property (p_floor2)
    else $error("drive 2 floor duty wrong");

  property p_floor3;
    AUTO_MODE_IN[2] && BELOW_HYST_IN[2] |=>
      FAN_DRIVE_OUTPUT_DUTY_OUT[2] ==
      ($past(floor_bits[2]) ? $past(MIN_DUTY_IN[2]) : 8'h00);
  endproperty
  a_floor3: assert property (p_floor3)
    else $error("drive 3 floor duty wrong");

  property p_track;
    RESET_N_IN && !(AUTO_MODE_IN[2] && BELOW_HYST_IN[2]) |=>
      FAN_DRIVE_OUTPUT_DUTY_OUT[2] == $past(CALC_DUTY_IN[2]);
  endproperty
  a_track: assert property (p_track)
    else $error("drive 3 not tracking computed duty");

  property p_lock_hold;
    LOCKED_OUT |=> $stable(state_ff.sync_floor) && $stable(state_ff.acou2)
                   && LOCKED_OUT;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("locked settings changed");

  property p_unlocked_write;
    RESET_N_IN && !LOCKED_OUT && REG_WR_IN &&
    REG_ADDR_IN == `FTSM_ADDR_SYNC_FLOOR |=>
      state_ff.sync_floor == $past(REG_WDATA_IN);
  endproperty
  a_unlocked_write: assert property (p_unlocked_write)
    else $error("unlocked write not taken");

  property p_acou2_reset;
    !rst_seen_ff |-> state_ff.acou2 == 8'h00;
  endproperty
  a_acou2_reset: assert property (p_acou2_reset)
    else $error("register 0x63 not zero after reset");

  property p_read_once;
    RESET_N_IN && REG_RD_IN && REG_ADDR_IN == `FTSM_ADDR_ACOU2 |=>
      REG_RDATA_OUT == $past(state_ff.acou2) ##1
      (REG_RDATA_OUT == 8'h00 || $past(REG_RD_IN));
  endproperty
  a_read_once: assert property (p_read_once)
    else $error("read data of 0x63 wrong or held");

  // Outside the below-threshold case every drive output simply
  // follows the loop's computed duty one cycle later.
  property p_track1;
    RESET_N_IN && !(AUTO_MODE_IN[0] && BELOW_HYST_IN[0]) |=>
      FAN_DRIVE_OUTPUT_DUTY_OUT[0] == $past(CALC_DUTY_IN[0]);
  endproperty
  a_track1: assert property (p_track1)
    else $error("drive 1 not tracking computed duty");

  property p_track2;
    RESET_N_IN && !(AUTO_MODE_IN[1] && BELOW_HYST_IN[1]) |=>
      FAN_DRIVE_OUTPUT_DUTY_OUT[1] == $past(CALC_DUTY_IN[1]);
  endproperty
  a_track2: assert property (p_track2)
    else $error("drive 2 not tracking computed duty");

  property p_lock_set;
    RESET_N_IN && REG_WR_IN && REG_ADDR_IN == `FTSM_ADDR_CONFIG &&
    REG_WDATA_IN[`FTSM_BIT_LOCK] |=> LOCKED_OUT;
  endproperty
  a_lock_set: assert property (p_lock_set)
    else $error("lock bit write not taken");

  property p_cfg_read;
    RESET_N_IN && REG_RD_IN && REG_ADDR_IN == `FTSM_ADDR_CONFIG |=>
      REG_RDATA_OUT == {6'h00, $past(LOCKED_OUT), 1'b0};
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("config read does not show the lock");

  property p_acou2_write;
    RESET_N_IN && !LOCKED_OUT && REG_WR_IN &&
    REG_ADDR_IN == `FTSM_ADDR_ACOU2 |=> state_ff.acou2 == $past(REG_WDATA_IN);
  endproperty
  a_acou2_write: assert property (p_acou2_write)
    else $error("unlocked write to 0x63 not taken");

  property p_read_sf;
    RESET_N_IN && REG_RD_IN && REG_ADDR_IN == `FTSM_ADDR_SYNC_FLOOR |=>
      REG_RDATA_OUT == $past(state_ff.sync_floor);
  endproperty
  a_read_sf: assert property (p_read_sf)
    else $error("sync and floor read data wrong");

  // Idle read data is zero so a late sample cannot pass for a read
  property p_rdata_idle;
    RESET_N_IN && !REG_RD_IN |=> REG_RDATA_OUT == `FTSM_RDATA_IDLE;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data held without a read");

  c_lock_write: cover property (LOCKED_OUT && REG_WR_IN &&
                                REG_ADDR_IN == `FTSM_ADDR_SYNC_FLOOR);
  c_floor_held: cover property (AUTO_MODE_IN[0] && BELOW_HYST_IN[0] &&
                                floor_bits[0]);
  c_sync_on:    cover property (sync_bit && FAN_DRIVE_OUTPUT_3_LEVEL_IN);
  c_sync_off:   cover property (!sync_bit && !FAN_DRIVE_OUTPUT_3_LEVEL_IN);
  c_floor_off:  cover property (AUTO_MODE_IN[2] && BELOW_HYST_IN[2] &&
                                !floor_bits[2]);

endmodule // ftsm_ctrl

//--- rtl/ftsm_pkg.sv
/*
  Types shared by the fan sync and floor block.
  Assumes the constants of ftsm_regs.svh are used beside it.
*/
package ftsm_pkg;

  typedef logic [7:0] ftsm_byte_t;

  typedef struct packed {
    ftsm_byte_t       sync_floor;
    ftsm_byte_t       acou2;
    logic             lock;
    ftsm_byte_t       rdata;
    ftsm_byte_t [2:0] duty;
    logic       [2:0] sense_gate;
    logic       [2:0] below_active;
  } ftsm_state_t;

endpackage

//--- rtl/ftsm_regs.svh
/*
  Offsets, field positions and reset values of the fan sync and floor block.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef FTSM_REGS_SVH
`define FTSM_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FTSM_ADDR_CONFIG      8'h40
`define FTSM_ADDR_STATUS      8'h41
`define FTSM_ADDR_SYNC_FLOOR  8'h62
`define FTSM_ADDR_ACOU2       8'h63

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FTSM_RST_SYNC_FLOOR   8'h00
`define FTSM_RST_ACOU2        8'h00
`define FTSM_RDATA_IDLE       8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FTSM_BIT_LOCK         1
`define FTSM_BIT_SYNC         4
`define FTSM_BIT_FLOOR1       5
`define FTSM_BIT_FLOOR2       6
`define FTSM_BIT_FLOOR3       7
`define FTSM_DUTY_OFF         8'h00
`define FTSM_CHANNELS         3

`endif
